// ===== hw/rgm_mac_end.sv
// mac end of the reduced-pin gigabit link with an axi4-lite register port
//
// Implementation choice: register access over AXI4-Lite.
`include "rgm_params.svh"
module rgm_mac_end
   import rgm_pkg::*;
#(
   parameter int LINK_CYC = `RGM_LINK_CYC,
   parameter int DEPTH    = 32
) (
   // clock and reset
   input  logic        aclk,
   input  logic        aresetn,
   // link toward the phy
   rgm_link_if.mac     lnk,
   // axi4-lite write
   input  logic [11:0] s_axi_awaddr,
   input  logic        s_axi_awvalid,
   output logic        s_axi_awready,
   input  logic [31:0] s_axi_wdata,
   input  logic [3:0]  s_axi_wstrb,
   input  logic        s_axi_wvalid,
   output logic        s_axi_wready,
   output logic [1:0]  s_axi_bresp,
   output logic        s_axi_bvalid,
   input  logic        s_axi_bready,
   // axi4-lite read
   input  logic [11:0] s_axi_araddr,
   input  logic        s_axi_arvalid,
   output logic        s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0]  s_axi_rresp,
   output logic        s_axi_rvalid,
   input  logic        s_axi_rready
);
   localparam logic [7:0] PH_LAST = 8'(LINK_CYC - 1);
   localparam logic [7:0] HALF    = 8'(LINK_CYC / 2);
   localparam logic [7:0] Q1      = 8'(LINK_CYC / 4);
   localparam logic [7:0] Q3      = 8'(3 * LINK_CYC / 4);

   logic [7:0]  ph_r;
   logic        clk_r;
   logic [3:0]  txd_r;
   logic        txc_r;
   logic        dslot_r;
   logic [8:0]  hold_r;
   logic        txen_r;
   logic [5:0]  s1_r;
   logic [5:0]  s2_r;
   logic        ck_d_r;
   logic [3:0]  lo_r;
   logic        cr_r;
   logic [3:0]  ibs_r;
   logic [7:0]  fc_r;
   logic [8:0]  rxb_r;
   logic        rxv_r;
   logic        ovr_r;
   logic        awr_r;
   logic        bv_r;
   logic [1:0]  br_r;
   logic        arr_r;
   logic        rv_r;
   logic [1:0]  rr_r;
   logic [31:0] rd_r;
   logic        f_in_ready;
   logic        f_out_valid;
   logic [8:0]  f_out_data;

   // transmit clock divider
   wire [7:0] ph_nxt = (ph_r == PH_LAST) ? 8'h00 : ph_r + 8'h01;
   wire lo_slot      = (ph_r == Q3);
   wire hi_slot      = (ph_r == Q1);
   wire pop          = lo_slot & txen_r & f_out_valid;
   wire aw_tx        = (s_axi_awaddr == `RGM_MAC_TXDATA);
   wire wr_fire      = awr_r;

   // transmit byte queue; drains one byte per link period
   rgm_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_txq (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (wr_fire & aw_tx & s_axi_wstrb[0]),
      .in_data   (s_axi_wdata[8:0]),
      .in_ready  (f_in_ready),
      .out_valid (f_out_valid),
      .out_data  (f_out_data),
      .out_ready (pop)
   );

   // transmit clock and pins: lower nibble before rise, upper before fall
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph_r    <= PH_LAST;                           // first period after reset has a full high half
         clk_r   <= 1'b0;
         txd_r   <= 4'h0;
         txc_r   <= 1'b0;
         dslot_r <= 1'b0;
         hold_r  <= 9'h000;
      end else begin
         ph_r  <= ph_nxt;
         clk_r <= (ph_nxt < HALF);
         if (lo_slot) begin
            dslot_r <= pop;
            txd_r   <= pop ? f_out_data[3:0] : 4'h0;
            txc_r   <= pop;
            hold_r  <= f_out_data;
         end else if (hi_slot) begin
            txd_r <= dslot_r ? hold_r[7:4] : 4'h0;
            txc_r <= dslot_r & hold_r[8];
         end
      end
   end

   // receive pins through two-flop synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r   <= 6'h00;
         s2_r   <= 6'h00;
         ck_d_r <= 1'b0;
      end else begin
         s1_r   <= {lnk.rx_clk, lnk.rx_ctl, lnk.rx_d};
         s2_r   <= s1_r;
         ck_d_r <= s2_r[5];
      end
   end

   // data recovered on the edges of the phy receive clock
   wire rx_rise  = s2_r[5] & ~ck_d_r;
   wire rx_fall  = ~s2_r[5] & ck_d_r;
   rgm_kind_e kind;
   assign kind   = rgm_decode(cr_r, s2_r[4]);
   wire rx_new   = rx_fall & ((kind == RGM_DATA) | (kind == RGM_ERR));
   wire rx_pop   = arr_r & (s_axi_araddr == `RGM_MAC_RXDATA);
   wire fc_seen  = rx_fall & (kind == RGM_RSVD) & (lo_r == `RGM_FALSE_CARRIER);

   // receive decode: bytes, in-band status only while idle, false carriers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lo_r  <= 4'h0;
         cr_r  <= 1'b0;
         ibs_r <= 4'h0;
         fc_r  <= 8'h00;
         rxb_r <= 9'h000;
      end else begin
         if (rx_rise) lo_r <= s2_r[3:0];
         if (rx_rise) cr_r <= s2_r[4];
         if (rx_fall && kind == RGM_IDLE) ibs_r <= lo_r;
         if (fc_seen) fc_r <= fc_r + 8'h01;
         if (rx_new) rxb_r <= {kind == RGM_ERR, s2_r[3:0], lo_r};
      end
   end

   // byte-ready and overrun flags; a new byte wins over the read that clears byte-ready, but the read wins for overrun
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxv_r <= 1'b0;
         ovr_r <= 1'b0;
      end else begin
         rxv_r <= rx_new | (rxv_r & ~rx_pop);
         ovr_r <= (rx_new & rxv_r & ~rx_pop) | (ovr_r & ~rx_pop);
      end
   end

   // write channel: address and data taken together once both are offered
   wire wr_go  = s_axi_awvalid & s_axi_wvalid & ~awr_r & ~bv_r & (~aw_tx | f_in_ready);
   wire wr_map = aw_tx | (s_axi_awaddr == `RGM_MAC_CTRL) |
                 (s_axi_awaddr == `RGM_MAC_STATUS) | (s_axi_awaddr == `RGM_MAC_RXDATA);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awr_r  <= 1'b0;
         bv_r   <= 1'b0;
         br_r   <= `RGM_RESP_OKAY;
         txen_r <= `RGM_CTRL_RST;
      end else begin
         awr_r <= wr_go;
         if (wr_fire) begin
            bv_r <= 1'b1;
            br_r <= wr_map ? `RGM_RESP_OKAY : `RGM_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bv_r <= 1'b0;
         end
         if (wr_fire && s_axi_awaddr == `RGM_MAC_CTRL && s_axi_wstrb[0])
            txen_r <= s_axi_wdata[`RGM_CTRL_TXEN_BIT];
      end
   end

   // read mux: status holds in-band speed, link, duplex and flags
   wire [31:0] status = {16'h0000, fc_r, 1'b0, ~f_out_valid, ovr_r, rxv_r, ibs_r};
   wire        rd_go  = s_axi_arvalid & ~arr_r & ~rv_r;
   wire [31:0] rmux   = (s_axi_araddr == `RGM_MAC_CTRL)   ? {31'h0, txen_r} :
                        (s_axi_araddr == `RGM_MAC_STATUS) ? status :
                        (s_axi_araddr == `RGM_MAC_RXDATA) ? {22'h0, rxv_r, rxb_r} : 32'h0;
   wire        r_map  = (s_axi_araddr == `RGM_MAC_CTRL) | (s_axi_araddr == `RGM_MAC_STATUS) |
                        (s_axi_araddr == `RGM_MAC_RXDATA) | (s_axi_araddr == `RGM_MAC_TXDATA);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arr_r <= 1'b0;
         rv_r  <= 1'b0;
         rr_r  <= `RGM_RESP_OKAY;
         rd_r  <= 32'h0;
      end else begin
         arr_r <= rd_go;
         if (arr_r) begin
            rv_r <= 1'b1;
            rd_r <= rmux;
            rr_r <= r_map ? `RGM_RESP_OKAY : `RGM_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rv_r <= 1'b0;
         end
      end
   end

   // outputs
   assign s_axi_awready = awr_r;
   assign s_axi_wready  = awr_r;
   assign s_axi_bvalid  = bv_r;
   assign s_axi_bresp   = br_r;
   assign s_axi_arready = arr_r;
   assign s_axi_rvalid  = rv_r;
   assign s_axi_rresp   = rr_r;
   assign s_axi_rdata   = rd_r;
   assign lnk.tx_clk    = clk_r;
   assign lnk.tx_ctl    = txc_r;
   assign lnk.tx_d      = txd_r;
endmodule

// ===== hw/rgm_params.svh
// constants shared by both ends of the reduced-pin gigabit mac link
`ifndef RGM_PARAMS_SVH
`define RGM_PARAMS_SVH
// timing: system clock and generated link clock periods in ns
`define RGM_CLK_NS         20
`define RGM_LINK_NS        160
`define RGM_LINK_CYC       (`RGM_LINK_NS / `RGM_CLK_NS)
// in-band status codes
`define RGM_SPEED_2M5      2'h0
`define RGM_SPEED_25M      2'h1
`define RGM_SPEED_125M     2'h2
`define RGM_FALSE_CARRIER  4'hE
// device side serial interface configuration register
`define RGM_SER_CFG_ADDR   12'h608
`define RGM_SER_CFG_RST    16'h0001
`define RGM_SER_CFG_AN_BIT 0
// mac side register map (byte addresses)
`define RGM_MAC_CTRL       12'h000
`define RGM_MAC_STATUS     12'h004
`define RGM_MAC_TXDATA     12'h008
`define RGM_MAC_RXDATA     12'h00C
`define RGM_CTRL_TXEN_BIT  0
`define RGM_CTRL_RST       1'h0
// axi responses
`define RGM_RESP_OKAY      2'h0
`define RGM_RESP_SLVERR    2'h2
`endif

// ===== hw/rgm_pkg.sv
// types and control-pair decoding shared by both ends
package rgm_pkg;
   // kind of link symbol carried by one clock period
   typedef enum logic [3:0] {
      RGM_IDLE = 4'h1,
      RGM_DATA = 4'h2,
      RGM_RSVD = 4'h4,
      RGM_ERR  = 4'h8
   } rgm_kind_e;
   // what the device sends in the current receive period
   typedef enum logic [2:0] {
      RGM_SL_STAT = 3'h1,
      RGM_SL_DATA = 3'h2,
      RGM_SL_FC   = 3'h4
   } rgm_slot_e;
   // control pair (rising edge, falling edge) to symbol kind
   function automatic rgm_kind_e rgm_decode(input logic c_rise, input logic c_fall);
      case ({c_rise, c_fall})
         2'b00:   return RGM_IDLE;
         2'b10:   return RGM_DATA;
         2'b11:   return RGM_ERR;
         default: return RGM_RSVD;
      endcase
   endfunction
endpackage

// ===== hw/rgm_link_if.sv
// link wires between the mac end and the phy end
interface rgm_link_if;
   logic       tx_clk;
   logic       tx_ctl;
   logic [3:0] tx_d;
   logic       rx_clk;
   logic       rx_ctl;
   logic [3:0] rx_d;
   // mac drives transmit, phy drives receive
   modport mac (output tx_clk, output tx_ctl, output tx_d,
                input  rx_clk, input  rx_ctl, input  rx_d);
   modport phy (input  tx_clk, input  tx_ctl, input  tx_d,
                output rx_clk, output rx_ctl, output rx_d);
endinterface

// ===== hw/rgm_fifo.sv
// synchronous fifo with valid and ready on both sides
module rgm_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  logic             aclk,
   input  logic             aresetn,
   // fill side
   input  logic             in_valid,
   input  logic [WIDTH-1:0] in_data,
   output logic             in_ready,
   // drain side
   output logic             out_valid,
   output logic [WIDTH-1:0] out_data,
   input  logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;
   // full when pointers differ only in the wrap bit
   assign in_ready  = ~((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid = (wp_r != rp_r);
   assign out_data  = mem[rp_r[AW-1:0]];
   // storage
   always_ff @(posedge aclk) begin
      if (push) mem[wp_r[AW-1:0]] <= in_data;
   end
   // pointers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop)  rp_r <= rp_r + 1'b1;
      end
   end
endmodule

// ===== hw/rgm_phy_end.sv
// phy end of the reduced-pin gigabit mac link
`include "rgm_params.svh"
module rgm_phy_end
   import rgm_pkg::*;
#(
   parameter int LINK_CYC = `RGM_LINK_CYC
) (
   // clock and reset
   input  logic        aclk,
   input  logic        aresetn,
   // link toward the mac
   rgm_link_if.phy     lnk,
   // line-side bytes to send to the mac
   input  logic        line_valid,
   input  logic [7:0]  line_data,
   input  logic        line_err,
   output logic        line_ready,
   // line-side state for in-band status
   input  logic        link_up,
   input  logic        full_duplex,
   input  logic [1:0]  speed,
   input  logic        false_carrier,
   // bytes received from the mac
   output logic        txo_valid,
   output logic [7:0]  txo_data,
   output logic        txo_err,
   output logic        txo_rsvd,
   // configuration port
   input  logic        cfg_wr,
   input  logic        cfg_rd,
   input  logic [11:0] cfg_addr,
   input  logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   output logic        ser_an_en
);
   localparam logic [7:0] PH_LAST = 8'(LINK_CYC - 1);
   localparam logic [7:0] HALF    = 8'(LINK_CYC / 2);
   localparam logic [7:0] Q1      = 8'(LINK_CYC / 4);
   localparam logic [7:0] Q3      = 8'(3 * LINK_CYC / 4);

   // receive clock divider state
   logic [7:0]  ph_r;
   logic [7:0]  ph_nxt;
   logic        clk_r;
   logic        rdy_r;
   // receive drive state
   rgm_slot_e   slot_r;
   rgm_slot_e   slot_nxt;
   logic [7:0]  hold_r;
   logic        herr_r;
   logic [3:0]  rxd_r;
   logic [3:0]  rxd_nxt;
   logic        rxc_r;
   logic        rxc_nxt;
   logic        fc_pend_r;
   // transmit sampling state
   logic [5:0]  s1_r;
   logic [5:0]  s2_r;
   logic        ck_d_r;
   logic [3:0]  lo_r;
   logic        cr_r;
   logic        tv_r;
   logic [7:0]  td_r;
   logic        te_r;
   logic        tr_r;
   // configuration
   logic [15:0] cfg_r;
   logic [15:0] crd_r;

   // divider: clock high for the first half of each period
   assign ph_nxt = (ph_r == PH_LAST) ? 8'h00 : ph_r + 8'h01;
   wire lo_slot  = (ph_r == Q3);        // drive point before the rising edge
   wire hi_slot  = (ph_r == Q1);        // drive point before the falling edge
   wire take     = line_valid & rdy_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph_r  <= PH_LAST;               // first period after reset has a full high half
         clk_r <= 1'b0;
         rdy_r <= 1'b0;
      end else begin
         ph_r  <= ph_nxt;
         clk_r <= (ph_nxt < HALF);
         rdy_r <= (ph_nxt == Q3);
      end
   end

   // in-band status nibble: duplex, speed, link
   wire [3:0] stat = {full_duplex, speed, link_up};
   wire fc_sent    = lo_slot & ~take & fc_pend_r;

   // choose what the receive pins carry at each drive point
   always_comb begin
      slot_nxt = slot_r;
      rxd_nxt  = rxd_r;
      rxc_nxt  = rxc_r;
      if (lo_slot) begin
         if (take) begin
            slot_nxt = RGM_SL_DATA;
            rxd_nxt  = line_data[3:0];
            rxc_nxt  = 1'b1;
         end else if (fc_pend_r) begin
            slot_nxt = RGM_SL_FC;
            rxd_nxt  = `RGM_FALSE_CARRIER;
            rxc_nxt  = 1'b0;
         end else begin
            slot_nxt = RGM_SL_STAT;
            rxd_nxt  = stat;
            rxc_nxt  = 1'b0;
         end
      end else if (hi_slot) begin
         case (slot_r)
            RGM_SL_DATA: begin
               rxd_nxt = hold_r[7:4];
               rxc_nxt = herr_r;
            end
            RGM_SL_FC: begin
               rxd_nxt = `RGM_FALSE_CARRIER;
               rxc_nxt = 1'b1;
            end
            default: begin
               rxd_nxt = stat;
               rxc_nxt = 1'b0;
            end
         endcase
      end
   end

   // receive pin registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_r <= RGM_SL_STAT;
         rxd_r  <= 4'h0;
         rxc_r  <= 1'b0;
      end else begin
         slot_r <= slot_nxt;
         rxd_r  <= rxd_nxt;
         rxc_r  <= rxc_nxt;
      end
   end

   // byte held for its upper nibble
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_r <= 8'h00;
         herr_r <= 1'b0;
      end else if (take) begin
         hold_r <= line_data;
         herr_r <= line_err;
      end
   end

   // false carrier waits for an idle period; a new one wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) fc_pend_r <= 1'b0;
      else          fc_pend_r <= false_carrier | (fc_pend_r & ~fc_sent);
   end

   // transmit pins: two-flop synchronisers for clock, control and data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r   <= 6'h00;
         s2_r   <= 6'h00;
         ck_d_r <= 1'b0;
      end else begin
         s1_r   <= {lnk.tx_clk, lnk.tx_ctl, lnk.tx_d};
         s2_r   <= s1_r;
         ck_d_r <= s2_r[5];
      end
   end

   // edges of the mac transmit clock, from which data is recovered
   wire tx_rise = s2_r[5] & ~ck_d_r;
   wire tx_fall = ~s2_r[5] & ck_d_r;
   rgm_kind_e kind;
   assign kind = rgm_decode(cr_r, s2_r[4]);

   // lower nibble and control taken at the rising edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lo_r <= 4'h0;
         cr_r <= 1'b0;
      end else if (tx_rise) begin
         lo_r <= s2_r[3:0];
         cr_r <= s2_r[4];
      end
   end

   // whole byte and its kind at the falling edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tv_r <= 1'b0;
         td_r <= 8'h00;
         te_r <= 1'b0;
         tr_r <= 1'b0;
      end else begin
         tv_r <= tx_fall & ((kind == RGM_DATA) | (kind == RGM_ERR));
         te_r <= tx_fall & (kind == RGM_ERR);
         tr_r <= tx_fall & (kind == RGM_RSVD);
         if (tx_fall) td_r <= {s2_r[3:0], lo_r};
      end
   end

   // serial configuration register; bit 0 enables auto-negotiation
   wire cfg_hit = (cfg_addr == `RGM_SER_CFG_ADDR);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= `RGM_SER_CFG_RST;
         crd_r <= 16'h0000;
      end else begin
         if (cfg_wr && cfg_hit) cfg_r <= cfg_wdata;
         crd_r <= (cfg_rd && cfg_hit) ? cfg_r : 16'h0000;
      end
   end

   // outputs; the serial lanes themselves are analogue and lie outside
   assign ser_an_en   = cfg_r[`RGM_SER_CFG_AN_BIT];
   assign cfg_rdata   = crd_r;
   assign line_ready  = rdy_r;
   assign txo_valid   = tv_r;
   assign txo_data    = td_r;
   assign txo_err     = te_r;
   assign txo_rsvd    = tr_r;
   assign lnk.rx_clk  = clk_r;
   assign lnk.rx_ctl  = rxc_r;
   assign lnk.rx_d    = rxd_r;
endmodule

// ===== bench/rgm_link_props.sv
// concurrent checks on the link wires between the mac end and the phy end
module rgm_link_props (
   // clock and reset
   input logic       aclk,
   input logic       aresetn,
   // transmit wires made by the mac end
   input logic       tx_clk,
   input logic       tx_ctl,
   input logic [3:0] tx_d,
   // receive wires made by the phy end
   input logic       rx_clk,
   input logic       rx_ctl,
   input logic [3:0] rx_d
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // link clocks: four cycles high, four low, with no stretched or short phases
   a_tx_clk_shape: assert property ($rose(tx_clk) |-> tx_clk[*4] ##1 !tx_clk[*4] ##1 tx_clk)
      else $error("tx link clock period wrong");
   a_rx_clk_shape: assert property ($rose(rx_clk) |-> rx_clk[*4] ##1 !rx_clk[*4] ##1 rx_clk)
      else $error("rx link clock period wrong");
   // a low control on the rising half is never followed by a high falling half
   a_tx_no_rsvd: assert property ($rose(tx_clk) && !tx_ctl |-> ##4 !tx_ctl)
      else $error("reserved control pair on tx");
   // error flagged on the falling half of idle only as a false carrier marker
   a_rx_fc_marker: assert property ($rose(rx_clk) && !rx_ctl ##4 rx_ctl |-> rx_d == 4'hE)
      else $error("idle error half without marker nibble");
   // in-band speed field of a clean idle period never carries the reserved code
   a_rx_speed_code: assert property ($rose(rx_clk) && !rx_ctl ##4 !rx_ctl |-> rx_d[2:1] != 2'h3)
      else $error("reserved speed code in status");
   // nibbles and control settle before each link clock edge
   a_tx_setup_held: assert property (($rose(tx_clk) || $fell(tx_clk)) |-> $stable(tx_d) && $stable(tx_ctl))
      else $error("tx wires moved at link edge");
   a_rx_setup_held: assert property (($rose(rx_clk) || $fell(rx_clk)) |-> $stable(rx_d) && $stable(rx_ctl))
      else $error("rx wires moved at link edge");
   // reset leaves both directions quiet with clocks low
   a_link_quiet_reset: assert property (disable iff (1'h0) !aresetn |=> !tx_clk && !rx_clk && !tx_ctl && !rx_ctl)
      else $error("link active after reset");

   // main traffic kinds seen on the wires
   c_tx_data: cover property ($rose(tx_clk) && tx_ctl);
   c_rx_data: cover property ($rose(rx_clk) && rx_ctl);
   c_rx_fc: cover property ($rose(rx_clk) && !rx_ctl ##4 rx_ctl);
endmodule

// ===== bench/phy_mac_side_gmii_interface_tb_top.sv
// self-checking bench for the mac end and phy end joined by the link
`include "rgm_params.svh"
module phy_mac_side_gmii_interface_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // clock, reset and axi master
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr, cfg_addr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, speed;
   // phy line side and configuration port
   logic        line_valid, line_err, line_ready, link_up, full_duplex, false_carrier;
   logic        txo_valid, txo_err, txo_rsvd, cfg_wr, cfg_rd, ser_an_en;
   logic [7:0]  line_data, txo_data;
   logic [15:0] cfg_wdata, cfg_rdata;
   logic [8:0]  got_q[$];
   int          rsvd_n, failures, checks_done;

   always #10 aclk = ~aclk;

   rgm_link_if i_rgm_link_if ();
   rgm_mac_end i_rgm_mac_end (.aclk(aclk), .aresetn(aresetn), .lnk(i_rgm_link_if),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   rgm_phy_end i_rgm_phy_end (.aclk(aclk), .aresetn(aresetn), .lnk(i_rgm_link_if),
      .line_valid(line_valid), .line_data(line_data), .line_err(line_err), .line_ready(line_ready),
      .link_up(link_up), .full_duplex(full_duplex), .speed(speed), .false_carrier(false_carrier),
      .txo_valid(txo_valid), .txo_data(txo_data), .txo_err(txo_err), .txo_rsvd(txo_rsvd),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .ser_an_en(ser_an_en));
   rgm_link_props i_rgm_link_props (.aclk(aclk), .aresetn(aresetn),
      .tx_clk(i_rgm_link_if.tx_clk), .tx_ctl(i_rgm_link_if.tx_ctl), .tx_d(i_rgm_link_if.tx_d),
      .rx_clk(i_rgm_link_if.rx_clk), .rx_ctl(i_rgm_link_if.rx_ctl), .rx_d(i_rgm_link_if.rx_d));

   // collect bytes handed out by the phy end and count reserved pairs
   always @(posedge aclk) begin
      if (txo_valid) got_q.push_back({txo_err, txo_data});
      if (txo_rsvd) rsvd_n++;
   end

   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask

   task automatic tmo(input string nm);
      $display("ERROR %s expected answer seen timeout", nm);
      failures++;
      results();
   endtask

   // one axi4-lite write; bready held until the response is sampled
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int i;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 200; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      if (i == 200) tmo("axi write");
      r = bresp;
      bready <= 1'h0;
      @(posedge aclk);
   endtask

   // one axi4-lite read
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 200; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      if (i == 200) tmo("axi read");
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      @(posedge aclk);
   endtask

   // read a register until the masked bits match, bounded
   task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] w, output logic [31:0] d);
      logic [1:0] r;
      for (int i = 0; i < 40; i++) begin
         axi_rd(a, d, r);
         if ((d & m) === w) break;
      end
   endtask

   // configuration port access to the serial interface register
   task automatic cfg_acc(input logic wr, input logic [15:0] wd, output logic [15:0] rd);
      cfg_addr <= `RGM_SER_CFG_ADDR;
      cfg_wdata <= wd;
      cfg_wr <= wr;
      cfg_rd <= !wr;
      @(posedge aclk);
      cfg_wr <= 1'h0;
      cfg_rd <= 1'h0;
      @(posedge aclk);
      rd = cfg_rdata;
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      logic [15:0] c;
      axi_rd(`RGM_MAC_CTRL, d, r);
      chk("ctrl reset", 32'h0, d);
      axi_rd(12'h010, d, r);
      chk("unmapped read resp", `RGM_RESP_SLVERR, r);
      axi_wr(12'h010, 32'h1, r);
      chk("unmapped write resp", `RGM_RESP_SLVERR, r);
      cfg_acc(1'h0, 16'h0, c);
      chk("serial cfg reset", `RGM_SER_CFG_RST, c);
      chk("autoneg on", 32'h1, ser_an_en);
      cfg_acc(1'h1, 16'h0, c);
      chk("autoneg off", 32'h0, ser_an_en);
      cfg_acc(1'h0, 16'h0, c);
      chk("serial cfg cleared", 32'h0, c);
      $display("test regs done");
   endtask

   // every speed code, both duplex states, link up and down
   task automatic t_status();
      logic [31:0] d;
      logic [3:0]  e;
      for (int s = 0; s < 4; s++) begin
         e = {s[0], (s == 3) ? 2'h1 : s[1:0], s != 3};
         speed <= e[2:1];
         full_duplex <= e[3];
         link_up <= e[0];
         poll(`RGM_MAC_STATUS, 32'hF, {28'h0, e}, d);
         chk("inband status", {28'h0, e}, {28'h0, d[3:0]});
      end
      $display("test status done");
   endtask

   // bytes queued while transmit is off, then sent back to back
   task automatic t_tx();
      logic [31:0] d;
      logic [1:0]  r;
      logic [8:0]  e[3] = '{9'h0A5, 9'h113, 9'h0FF};
      int          i;
      foreach (e[k]) axi_wr(`RGM_MAC_TXDATA, {23'h0, e[k]}, r);
      axi_rd(`RGM_MAC_STATUS, d, r);
      chk("fifo holds bytes", 32'h0, d[6]);
      axi_wr(`RGM_MAC_CTRL, 32'h1, r);
      for (i = 0; i < 400 && got_q.size() < 3; i++) @(posedge aclk);
      if (i == 400) tmo("tx bytes");
      foreach (e[k]) chk("tx byte", e[k], got_q[k]);
      poll(`RGM_MAC_STATUS, 32'h40, 32'h40, d);
      chk("fifo drained", 32'h1, d[6]);
      $display("test tx done");
   endtask

   // one line byte into the phy end, read back at the mac end
   task automatic t_rx_one(input logic [7:0] b, input logic er);
      logic [31:0] d;
      int          i;
      line_valid <= 1'h1;
      line_data <= b;
      line_err <= er;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (line_ready) break;
      end
      if (i == 50) tmo("line byte");
      line_valid <= 1'h0;
      @(posedge aclk);
      poll(`RGM_MAC_RXDATA, 32'h200, 32'h200, d);
      chk("rx byte", {22'h0, 1'h1, er, b}, {22'h0, d[9:0]});
   endtask

   task automatic t_rx();
      logic [31:0] d;
      t_rx_one(8'h3C, 1'h0);
      t_rx_one(8'hC3, 1'h1);
      false_carrier <= 1'h1;
      @(posedge aclk);
      false_carrier <= 1'h0;
      poll(`RGM_MAC_STATUS, 32'hFF00, 32'h100, d);
      chk("false carrier count", 32'h1, d[15:8]);
      $display("test rx done");
   endtask

   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, line_valid, line_err} = '0;
      {link_up, full_duplex, false_carrier, cfg_wr, cfg_rd, speed, line_data} = '0;
      {awaddr, araddr, cfg_addr, wdata, cfg_wdata} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs();
      t_status();
      t_tx();
      t_rx();
      chk("reserved pairs", 32'h0, rsvd_n);
      results();
   end
endmodule
